// file: logic/bcsp_port.sv
// Purpose: buffered clocked serial port engine and buffer
// Assumes: link clock slow against sys_clk (125 ns vs 8 ns)
// Notes: link domain only captures edges and data; engine in sys_clk
`include "bcsp_consts.svh"
module bcsp_port #(
   parameter int DEPTH = 32,
   parameter int IW = 5
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic serial_clock_pin_i,   // link clock when external
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   output logic serial_data_out_pin_o,
   output logic serial_data_out_pin_oe,
   input wire logic serial_data_in_pin,
   input wire logic select_n_pin,
   output logic byte_strobe_pin,
   input wire bcsp_pkg::bcsp_cfg_t cfg,
   input wire logic stf_set,              // write one to start/busy
   input wire logic stf_clr,              // write zero to start/busy
   input wire logic sol_wr,               // write output_level_bit
   input wire logic sol_val,
   input wire logic status_rd,            // status read, arms clears
   input wire logic ovr_clr,              // write zero to overrun_flag
   input wire logic wt_clr,               // write zero to access_conflict_flag
   input wire logic abt_clr,              // write zero to abort_flag
   input wire logic irq_clr,              // clear serial_irq_request
   input wire logic buf_rd,
   input wire logic buf_wr,
   input wire logic [IW-1:0] buf_idx,
   input wire logic [7:0] buf_wdata,
   output logic [7:0] buf_rdata,
   output bcsp_pkg::bcsp_stat_t stat,
   output logic serial_irq
);
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // half period reload for internal rates, code 0 as slowest
   function automatic logic [5:0] half_reload(input logic [2:0] sel);
      logic [2:0] c;
      c = (sel == 3'h0) ? 3'h1 : sel;
      half_reload = 6'(((7'h01 << (`BCSP_RATE_TOP - c)) - 7'h01));
   endfunction : half_reload

   // gap length in serial half periods
   function automatic logic [4:0] gap_ticks(input logic [1:0] g);
      case (g)
         2'h1: gap_ticks = `BCSP_GAP_T1;
         2'h2: gap_ticks = `BCSP_GAP_T2;
         default: gap_ticks = `BCSP_GAP_T3;
      endcase
   endfunction : gap_ticks

   // sticky flag: set wins over an armed clear
   function automatic logic flag_nxt(input logic cur, input logic set,
                                     input logic clr);
      flag_nxt = set | (cur & ~clr);
   endfunction : flag_nxt

   // ------------------------------------------------------------
   // link domain: edge toggles and captured data
   // ------------------------------------------------------------
   logic lk_rise_tgl_r;  // flips on each rising link edge
   logic lk_fall_tgl_r;  // flips on each falling link edge
   logic lk_rx_bit_r;    // data in sampled at rising link edge

   // rising edge capture
   always_ff @(posedge serial_clock_pin_i or negedge rst_n) begin
      if (!rst_n) begin
         lk_rise_tgl_r <= 1'b0;
         lk_rx_bit_r <= 1'b0;
      end else begin
         lk_rise_tgl_r <= ~lk_rise_tgl_r;
         lk_rx_bit_r <= serial_data_in_pin;
      end
   end

   // falling edge capture
   always_ff @(negedge serial_clock_pin_i or negedge rst_n) begin
      if (!rst_n) begin
         lk_fall_tgl_r <= 1'b0;
      end else begin
         lk_fall_tgl_r <= ~lk_fall_tgl_r;
      end
   end

   // ------------------------------------------------------------
   // synchronisers into sys_clk
   // ------------------------------------------------------------
   logic [2:0] rise_s_r;  // [0] first stage only feeds [1]
   logic [2:0] fall_s_r;
   logic [1:0] cs_s_r;
   logic [1:0] si_s_r;

   // two flops per level, third flop for toggle edges
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_s_r <= 3'h0;
         fall_s_r <= 3'h0;
         cs_s_r <= 2'h3;
         si_s_r <= 2'h0;
      end else begin
         rise_s_r <= {rise_s_r[1:0], lk_rise_tgl_r};
         fall_s_r <= {fall_s_r[1:0], lk_fall_tgl_r};
         cs_s_r <= {cs_s_r[0], select_n_pin};
         si_s_r <= {si_s_r[0], serial_data_in_pin};
      end
   end

   logic ext_mode;  // external clock chosen
   logic ext_rise;  // rising link edge seen
   logic ext_fall;  // falling link edge seen
   logic cs_high;   // select deasserted while function on
   assign ext_mode = (cfg.clk_sel == `BCSP_CLK_EXT);
   assign ext_rise = rise_s_r[2] ^ rise_s_r[1];
   assign ext_fall = fall_s_r[2] ^ fall_s_r[1];
   assign cs_high = cfg.cs_en & cs_s_r[1];

   // ------------------------------------------------------------
   // state and datapath registers
   // ------------------------------------------------------------
   bcsp_pkg::bcsp_state_t state_r;
   logic [7:0] mem_r [DEPTH];   // transfer buffer
   logic [IW-1:0] idx_r;        // current buffer index
   logic [7:0] tx_sh_r;         // byte being sent
   logic [7:0] rx_sh_r;         // byte being received
   logic [2:0] bit_cnt_r;       // rising edges done in byte
   logic [5:0] hc_r;            // internal half period timer
   logic sck_r;                 // internal clock level
   logic [4:0] gap_cnt_r;       // gap half periods left
   logic [1:0] byte_strobe_pin_cnt_r;      // strobe half periods left
   logic so_r;                  // data out level
   logic float_r;               // outputs floated after abort
   logic stf_r;
   logic ovr_r;
   logic wt_r;
   logic abt_r;
   logic irq_r;
   logic ovr_arm_r;
   logic wt_arm_r;
   logic abt_arm_r;
   logic [7:0] rdata_r;

   logic running;     // shifting or in gap
   logic tick;        // internal half period elapsed
   logic rise_ev;     // serial rising edge this cycle
   logic fall_ev;     // serial falling edge this cycle
   logic rx_bit;      // bit taken at rise_ev
   logic byte_done;   // eighth rising edge
   logic last_byte;   // current index is the end index
   logic do_start;    // accepted start request
   logic do_abort;    // select abort
   logic done;        // transfer complete
   logic [IW-1:0] idx_nxt;
   logic [7:0] rx_nxt;
   logic busy_acc;    // buffer access refused

   assign running = (state_r == bcsp_pkg::BCSP_SHIFT) || (state_r == bcsp_pkg::BCSP_GAP);
   assign tick = running && !ext_mode && (hc_r == 6'h00);
   assign rise_ev = (state_r == bcsp_pkg::BCSP_SHIFT) &&
                    (ext_mode ? ext_rise : (tick && !sck_r));
   assign fall_ev = (state_r == bcsp_pkg::BCSP_SHIFT) &&
                    (ext_mode ? ext_fall : (tick && sck_r));
   assign rx_bit = ext_mode ? lk_rx_bit_r : si_s_r[1];
   assign rx_nxt = {rx_bit, rx_sh_r[7:1]};
   assign byte_done = rise_ev && (bit_cnt_r == `BCSP_BIT_LAST);
   assign last_byte = (idx_r == cfg.end_idx);
   // wrap from the top of the window to its bottom
   assign idx_nxt = (idx_r == `BCSP_IDX_TOP) ? `BCSP_IDX_BOT : idx_r + 5'h01;
   assign do_start = stf_set && !stf_r && !abt_r;
   assign do_abort = running && cs_high;
   assign done = byte_done && last_byte && !stf_clr && !do_abort;
   assign busy_acc = stf_r && (buf_rd || buf_wr);

   // ------------------------------------------------------------
   // engine state machine
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= bcsp_pkg::BCSP_IDLE;
      end else begin
         case (state_r)
            bcsp_pkg::BCSP_IDLE: begin
               if (do_start) begin
                  // wait for select low when the function is on
                  state_r <= cfg.cs_en ? bcsp_pkg::BCSP_WAIT : bcsp_pkg::BCSP_SHIFT;
               end
            end
            bcsp_pkg::BCSP_WAIT: begin
               if (stf_clr) begin
                  state_r <= bcsp_pkg::BCSP_IDLE;
               end else if (!cs_s_r[1]) begin
                  state_r <= bcsp_pkg::BCSP_SHIFT;
               end
            end
            bcsp_pkg::BCSP_SHIFT: begin
               if (stf_clr || do_abort || done) begin
                  state_r <= bcsp_pkg::BCSP_IDLE;
               end else if (byte_done && !ext_mode && cfg.gap_len != 2'h0) begin
                  state_r <= bcsp_pkg::BCSP_GAP;
               end
            end
            bcsp_pkg::BCSP_GAP: begin
               if (stf_clr || do_abort) begin
                  state_r <= bcsp_pkg::BCSP_IDLE;
               end else if (tick && gap_cnt_r == 5'h01) begin
                  state_r <= bcsp_pkg::BCSP_SHIFT;
               end
            end
            default: begin
               state_r <= bcsp_pkg::BCSP_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // internal clock generator and gap timing
   // ------------------------------------------------------------
   // clock idles high, toggles while shifting; low phase covers data in sync delay
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hc_r <= 6'h00;
         sck_r <= 1'b1;
         gap_cnt_r <= 5'h00;
         byte_strobe_pin_cnt_r <= 2'h0;
      end else begin
         if (!running) begin
            hc_r <= half_reload(cfg.clk_sel);
            sck_r <= 1'b1;
         end else if (tick) begin
            hc_r <= half_reload(cfg.clk_sel) + (fall_ev ? `BCSP_LOW_STRETCH : 6'h00);
            if (state_r == bcsp_pkg::BCSP_SHIFT) begin
               sck_r <= ~sck_r;
            end
         end else begin
            hc_r <= hc_r - 6'h01;
         end
         // gap keeps the clock high; strobe lasts one period
         if (state_r == bcsp_pkg::BCSP_SHIFT && byte_done) begin
            gap_cnt_r <= gap_ticks(cfg.gap_len);
            byte_strobe_pin_cnt_r <= cfg.strobe_en ? `BCSP_BYTE_STROBE_PIN_TICKS : 2'h0;
         end else if (state_r != bcsp_pkg::BCSP_GAP) begin
            byte_strobe_pin_cnt_r <= 2'h0;
         end else if (tick) begin
            gap_cnt_r <= gap_cnt_r - 5'h01;
            byte_strobe_pin_cnt_r <= (byte_strobe_pin_cnt_r == 2'h0) ? 2'h0 : byte_strobe_pin_cnt_r - 2'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // shifters and index
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_r <= '0;
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         bit_cnt_r <= 3'h0;
      end else if (do_start) begin
         idx_r <= cfg.start_idx;
         tx_sh_r <= mem_r[cfg.start_idx];
         bit_cnt_r <= 3'h0;
      end else if (rise_ev) begin
         rx_sh_r <= rx_nxt;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (byte_done && !last_byte) begin
            idx_r <= idx_nxt;
            tx_sh_r <= mem_r[idx_nxt];
         end
      end
   end

   // ------------------------------------------------------------
   // transfer buffer
   // ------------------------------------------------------------
   // receive writes back in place; transmit only never writes
   always_ff @(posedge sys_clk) begin
      if (byte_done && cfg.rx_en && !stf_clr && !do_abort) begin
         mem_r[idx_r] <= rx_nxt;
      end else if (buf_wr && !stf_r) begin
         mem_r[buf_idx] <= buf_wdata;
      end
   end

   // cpu read port, refused reads return all ones
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else if (buf_rd) begin
         rdata_r <= stf_r ? `BCSP_RD_REFUSED : mem_r[buf_idx];
      end
   end

   // ------------------------------------------------------------
   // data out level
   // ------------------------------------------------------------
   // next bit on falling edge, last bit held after the end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         so_r <= `BCSP_SO_RST;
      end else if (fall_ev && cfg.tx_en) begin
         so_r <= tx_sh_r[bit_cnt_r];
      end else if (sol_wr && !stf_r) begin
         so_r <= sol_val;
      end
   end

   // float after select abort until restart or level write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         float_r <= 1'b0;
      end else if (do_abort) begin
         float_r <= 1'b1;
      end else if (do_start || sol_wr) begin
         float_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // start/busy flag
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stf_r <= 1'b0;
      end else if (do_start) begin
         stf_r <= 1'b1;
      end else if (stf_clr || done || do_abort) begin
         stf_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // error flags, cleared by zero after being read as one
   // ------------------------------------------------------------
   logic ovr_set;
   logic abt_set;
   // any rising external edge while stopped, unless deselected
   assign ovr_set = ext_mode && !stf_r && ext_rise && !cs_high;
   assign abt_set = do_abort;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_arm_r <= 1'b0;
         wt_arm_r <= 1'b0;
         abt_arm_r <= 1'b0;
      end else begin
         ovr_arm_r <= (status_rd && ovr_r) || (ovr_arm_r && ovr_r && !ovr_clr);
         wt_arm_r <= (status_rd && wt_r) || (wt_arm_r && wt_r && !wt_clr);
         abt_arm_r <= (status_rd && abt_r) || (abt_arm_r && abt_r && !abt_clr);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_r <= 1'b0;
         wt_r <= 1'b0;
         abt_r <= 1'b0;
      end else begin
         ovr_r <= flag_nxt(ovr_r, ovr_set, ovr_clr && ovr_arm_r);
         wt_r <= flag_nxt(wt_r, busy_acc, wt_clr && wt_arm_r);
         abt_r <= flag_nxt(abt_r, abt_set, abt_clr && abt_arm_r);
      end
   end

   // shared request for completion and abort
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_nxt(irq_r, done || do_abort, irq_clr);
      end
   end

   // ------------------------------------------------------------
   // pins and status
   // ------------------------------------------------------------
   assign serial_clock_pin_o = sck_r;
   // driven only with internal clock and serial function
   assign serial_clock_pin_oe = cfg.sck_fn && !ext_mode && !float_r;
   // open drain only pulls low
   assign serial_data_out_pin_o = cfg.open_drain ? 1'b0 : so_r;
   assign serial_data_out_pin_oe = cfg.so_fn && !float_r && (!cfg.open_drain || !so_r);
   assign byte_strobe_pin = (byte_strobe_pin_cnt_r != 2'h0) && (state_r == bcsp_pkg::BCSP_GAP);
   assign buf_rdata = rdata_r;
   assign serial_irq = irq_r && cfg.irq_en;
   assign stat.start_busy_flag = stf_r;
   assign stat.overrun_flag = ovr_r;
   assign stat.access_conflict_flag = wt_r;
   assign stat.abort_flag = abt_r;
   assign stat.output_level_bit = so_r;
   assign stat.serial_irq_request = irq_r;
endmodule : bcsp_port

// file: pkg/bcsp_consts.svh
// Purpose: constants of the buffered clocked serial port
// Assumes: sys_clk at 125 MHz, link clock unrelated
// Notes: counts are in sys_clk cycles or serial half periods
`ifndef BCSP_CONSTS_SVH
`define BCSP_CONSTS_SVH
`define BCSP_CLK_EXT 3'h7
`define BCSP_RATE_TOP 3'h6
`define BCSP_IDX_TOP 5'h1f
`define BCSP_IDX_BOT 5'h00
`define BCSP_RD_REFUSED 8'hff
`define BCSP_GAP_T1 5'h04
`define BCSP_GAP_T2 5'h08
`define BCSP_GAP_T3 5'h10
`define BCSP_BYTE_STROBE_PIN_TICKS 2'h2
`define BCSP_BIT_LAST 3'h7
`define BCSP_SO_RST 1'b0
`define BCSP_LOW_STRETCH 6'h02
`endif

// file: pkg/bcsp_pkg.sv
// Purpose: types of the buffered clocked serial port
// Assumes: nothing
// Notes: one-hot engine states
package bcsp_pkg;
   // engine states
   typedef enum logic [3:0] {
      BCSP_IDLE = 4'b0001,
      BCSP_WAIT = 4'b0010,
      BCSP_SHIFT = 4'b0100,
      BCSP_GAP = 4'b1000
   } bcsp_state_t;

   // software configuration
   typedef struct packed {
      logic [2:0] clk_sel;    // 7 external, else internal rate
      logic [1:0] gap_len;    // 0 no gap
      logic strobe_en;        // strobe pin function
      logic cs_en;            // select input function
      logic open_drain;       // open_drain_select
      logic sck_fn;           // clock pin serial function
      logic so_fn;            // data out pin serial function
      logic si_fn;            // data in pin serial function
      logic tx_en;            // transmit enable
      logic rx_en;            // receive enable
      logic irq_en;           // serial_irq_enable
      logic [4:0] start_idx;  // start index
      logic [4:0] end_idx;    // end index
   } bcsp_cfg_t;

   // status shown to software
   typedef struct packed {
      logic start_busy_flag;
      logic overrun_flag;
      logic access_conflict_flag;
      logic abort_flag;
      logic output_level_bit;
      logic serial_irq_request;
   } bcsp_stat_t;
endpackage : bcsp_pkg

// file: dv/bcsp_port_monitor.sv
// Purpose: port checker for the buffered clocked serial port
// Assumes: one sys_clk domain, rst_n async low
// Notes: bound into every bcsp_port instance
module bcsp_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe,
   input wire logic serial_data_out_pin_oe,
   input wire bcsp_pkg::bcsp_cfg_t cfg,
   input wire logic stf_set,
   input wire logic stf_clr,
   input wire logic sol_wr,
   input wire logic sol_val,
   input wire logic buf_rd,
   input wire logic [7:0] buf_rdata,
   input wire bcsp_pkg::bcsp_stat_t stat,
   input wire logic serial_irq
);
   // -------------------------------
   // properties
   // -------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_busy_rd;
      stat.start_busy_flag && buf_rd |=> buf_rdata == 8'hff && stat.access_conflict_flag;
   endproperty
   a_busy_rd: assert property (p_busy_rd) else $error("busy read not refused");
   property p_irq_mask;
      serial_irq == (stat.serial_irq_request && cfg.irq_en);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq line mismatch");
   property p_abt_block;
      stat.abort_flag && stf_set |=> !stat.start_busy_flag;
   endproperty
   a_abt_block: assert property (p_abt_block) else $error("start while aborted");
   property p_sol_wr;
      !stat.start_busy_flag && sol_wr && !stf_set |=> stat.output_level_bit == $past(sol_val);
   endproperty
   a_sol_wr: assert property (p_sol_wr) else $error("level write lost");
   property p_clk_idle;
      !stat.start_busy_flag && !$past(stat.start_busy_flag) |-> serial_clock_pin_o;
   endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("clock moved while idle");
   property p_so_hold;
      !stat.start_busy_flag && !sol_wr && !stf_set |=> $stable(stat.output_level_bit);
   endproperty
   a_so_hold: assert property (p_so_hold) else $error("data out moved while idle");
   property p_abort_float;
      $rose(stat.abort_flag) |-> !stat.start_busy_flag && !serial_clock_pin_oe
         && !serial_data_out_pin_oe && stat.serial_irq_request;
   endproperty
   a_abort_float: assert property (p_abort_float) else $error("abort incomplete");
   property p_done_irq;
      $fell(stat.start_busy_flag) && !$past(stf_clr) |-> stat.serial_irq_request;
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("no request at end");
   c_done: cover property ($fell(stat.start_busy_flag));
   c_abort: cover property ($rose(stat.abort_flag));
   c_ovr: cover property ($rose(stat.overrun_flag));
endmodule : bcsp_monitor

bind bcsp_port bcsp_monitor u_mon (.sys_clk, .rst_n, .serial_clock_pin_o, .serial_clock_pin_oe,
   .serial_data_out_pin_oe, .cfg, .stf_set, .stf_clr, .sol_wr, .sol_val, .buf_rd, .buf_rdata,
   .stat, .serial_irq);

// file: dv/bcsp_peer.sv
// Purpose: external serial peripheral on the far side of the port
// Assumes: clock idles high, bits move lsb first
// Notes: its own clock runs only inside bursts the bench asks for
module bcsp_peer (
   input wire logic sck,
   input wire logic sdo,
   input wire logic clr,
   input wire logic [7:0] tx_byte,
   output logic sdi,
   output logic ext_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rx [0:63];  // bytes seen on data out
   logic [7:0] sh;
   logic [2:0] b = 3'h0;   // bit within byte
   int n = 0;              // whole bytes seen
   initial begin
      sdi = 1'b0;
      ext_clk = 1'b1;
   end
   // drive on falling, sample on rising
   always @(negedge sck) sdi <= tx_byte[b];
   always @(posedge sck or posedge clr) begin
      if (clr) begin
         b <= 3'h0;
         n <= 0;
      end else begin
         sh <= {sdo, sh[7:1]};
         b <= b + 3'h1;
         if (b == 3'h7) begin
            rx[n[5:0]] <= {sdo, sh[7:1]};
            n <= n + 1;
            sdi <= ~sdi;  // hold time over: show the other level
         end
      end
   end
   // clock burst of 125 ns periods, high between bursts
   task automatic pulses(int k);
      repeat (k) begin
         #62.5 ext_clk = 1'b0;
         #62.5 ext_clk = 1'b1;
      end
   endtask : pulses
endmodule : bcsp_peer

// file: dv/bcsp_tb.sv
// Purpose: self-checking bench of the buffered clocked serial port
// Assumes: peer model on the serial pins, pull-up on data, peer clock on an undriven clock pin
// Notes: xorshift stimulus, fixed seed
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, rst_n, sck_o, sck_oe, so_o, so_oe, sdi, strobe, irq, ext_clk, peer_clr;
   logic sel_n, stf_set, stf_clr, sol_wr, sol_val, status_rd, ovr_clr, wt_clr, abt_clr, irq_clr;
   logic buf_rd, buf_wr;
   logic [4:0] buf_idx, s;
   logic [7:0] buf_wdata, buf_rdata, peer_tx;
   logic [7:0] mem [0:31];  // expected buffer
   bcsp_pkg::bcsp_cfg_t cfg;
   bcsp_pkg::bcsp_stat_t stat;
   logic [31:0] seed = 32'hcb20;
   int errors = 0, comparisons = 0, cycles = 0, strobes = 0;
   wire logic sck_w = sck_oe ? sck_o : ext_clk;  // pin level
   wire logic so_w = so_oe ? so_o : 1'b1;
   wire logic [7:0] eflags = {5'h0, stat.overrun_flag, stat.access_conflict_flag, stat.abort_flag};
   bcsp_port dut (.sys_clk, .rst_n, .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
      .serial_clock_pin_oe(sck_oe), .serial_data_out_pin_o(so_o), .serial_data_out_pin_oe(so_oe),
      .serial_data_in_pin(sdi), .select_n_pin(sel_n), .byte_strobe_pin(strobe), .cfg, .stf_set,
      .stf_clr, .sol_wr, .sol_val, .status_rd, .ovr_clr, .wt_clr, .abt_clr, .irq_clr, .buf_rd,
      .buf_wr, .buf_idx, .buf_wdata, .buf_rdata, .stat, .serial_irq(irq));
   bcsp_peer peer (.sck(sck_w), .sdo(so_w), .clr(peer_clr), .tx_byte(peer_tx), .sdi, .ext_clk);
   always @(posedge strobe) strobes++;
   // ----------------------------
   // helpers
   // ----------------------------
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 90000) begin
         errors++;
         end_sim();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic pulse(ref logic p);
      @(negedge sys_clk) p = 1'b1;
      @(negedge sys_clk) p = 1'b0;
   endtask : pulse
   task automatic bufop(logic wr, logic [4:0] idx, logic [7:0] d);
      @(negedge sys_clk) {buf_wr, buf_rd, buf_idx, buf_wdata} = {wr, !wr, idx, d};
      @(negedge sys_clk) {buf_wr, buf_rd} = 2'b00;
   endtask : bufop
   // zero-clear needs a read that saw one
   task automatic clear_flags(logic [2:0] exp);
      for (int i = 0; i < 2; i++) begin
         if (i == 1) pulse(status_rd);
         @(negedge sys_clk) {ovr_clr, wt_clr, abt_clr} = 3'b111;
         @(negedge sys_clk) {ovr_clr, wt_clr, abt_clr} = 3'b000;
         chk("error flags", i ? 8'h00 : {5'h0, exp}, eflags);
      end
   endtask : clear_flags
   // one transfer: random buffer, start, compare wire and buffer
   task automatic xfer(logic [2:0] rate, logic [1:0] mode, logic [4:0] st, logic [4:0] e);
      int nb, sb;
      nb = ((e - st) & 31) + 1;
      for (int i = 0; i < 32; i++) begin
         mem[i] = 8'(rnd());
         bufop(1'b1, 5'(i), mem[i]);
      end
      peer_tx = 8'(rnd());
      pulse(peer_clr);
      pulse(irq_clr);
      sb = strobes;
      cfg.clk_sel = rate;
      {cfg.gap_len, cfg.rx_en, cfg.tx_en} = {rate[1:0], mode};
      {cfg.irq_en, cfg.cs_en} = {1'(rnd()), 1'b0};
      {cfg.start_idx, cfg.end_idx} = {st, e};
      pulse(stf_set);
      bufop(1'b0, st, 8'h00);
      chk("busy read", 8'hff, buf_rdata);
      bufop(1'b1, st, ~mem[st]);
      if (rate == 3'h7) peer.pulses(8 * nb);
      for (int i = 0; i < 9000 && stat.start_busy_flag !== 1'b0; i++) @(negedge sys_clk);
      chk("request", 8'h01, stat.serial_irq_request);
      chk("irq line", cfg.irq_en, irq);
      chk("byte count", 8'(nb), 8'(peer.n));
      sb = strobes - sb;
      chk("strobes", 8'((rate != 3'h7 && |rate[1:0]) ? nb - 1 : 0), 8'(sb));
      if (mode[0]) chk("last bit", mem[e][7], stat.output_level_bit);
      for (int k = 0; k < nb; k++) begin
         if (mode[0]) chk("wire byte", mem[(st + k) % 32], peer.rx[k]);
         if (mode[1]) mem[(st + k) % 32] = peer_tx;
      end
      for (int i = 0; i < 32; i++) begin
         bufop(1'b0, 5'(i), 8'h00);
         chk("buffer", mem[i], buf_rdata);
      end
      clear_flags(3'b010);
      $display("transfer rate %0d mode %0d done", rate, mode);
   endtask : xfer
   task automatic end_sim();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   // ----------------------------
   // sequence
   // ----------------------------
   initial begin
      {stf_set, stf_clr, sol_wr, sol_val, status_rd, ovr_clr, wt_clr, abt_clr, irq_clr} = '0;
      {buf_rd, buf_wr, buf_idx, buf_wdata, peer_tx, peer_clr, s} = '0;
      cfg = '0;
      {cfg.sck_fn, cfg.so_fn, cfg.si_fn, cfg.strobe_en} = 4'hf;
      {rst_n, sel_n} = 2'b01;
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      xfer(3'h6, 2'h3, 5'h1e, 5'h01);
      xfer(3'h5, 2'h1, 5'h09, 5'h09);
      for (int r = 1; r < 8; r++) begin
         s = 5'(rnd());
         xfer(3'(r), 2'(r % 3 + 1), s, 5'(s + rnd() % 4));
      end
      // stray external clocks after the end
      cfg.cs_en = 1'b1;
      peer.pulses(1);
      repeat (5) @(negedge sys_clk);
      chk("deselected", 8'h00, eflags);
      cfg.cs_en = 1'b0;
      peer.pulses(1);
      repeat (5) @(negedge sys_clk);
      clear_flags(3'b100);
      // select-gated start, then abort by select high
      {cfg.clk_sel, cfg.cs_en, cfg.start_idx, cfg.end_idx} = {3'h3, 1'b1, 10'h0};
      pulse(stf_set);
      bufop(1'b0, 5'h00, 8'h00);
      chk("waiting read", 8'hff, buf_rdata);
      chk("waiting", 8'h01, stat.start_busy_flag);
      sel_n = 1'b0;
      repeat (40) @(negedge sys_clk);
      sel_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk("abort", 8'h01, stat.abort_flag);
      pulse(stf_set);
      chk("refused start", 8'h00, stat.start_busy_flag);
      for (int v = 0; v < 2; v++) begin
         sol_val = 1'(v);
         pulse(sol_wr);
         chk("level", 8'(v), stat.output_level_bit);
         chk("drive", 8'h01, so_oe);
      end
      clear_flags(3'b011);
      $display("select and overrun test done");
      end_sim();
   end
endmodule : testbench
